// ===== c16sc_top.sv
`timescale 1ns/100ps
//==============================================
// two-socket control for 16-bit removable cards
module c16sc_top (
  // clock and reset
  input  wire logic                           clk_sys_i,
  input  wire logic                           rst_b_i,
  // socket configuration
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  cfg_io_mode_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  cfg_dma_en_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  cfg_dreq_ack_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  cfg_ring_mode_i,
  // host cycle requests
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  req_valid_i,
  input  wire c16sc_pkg::c16sc_kind_e         req_kind_i
                                              [c16sc_pkg::SOCKETS],
  input  wire logic [1:0]                     req_byte_en_i
                                              [c16sc_pkg::SOCKETS],
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  req_to_host_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  req_last_i,
  // host cycle status
  output logic [c16sc_pkg::SOCKETS-1:0]       req_busy_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       req_done_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       req_refused_o,
  // host card status
  output logic [c16sc_pkg::SOCKETS-1:0]       card_present_o,
  output c16sc_pkg::c16sc_batt_e              battery_state_o
                                              [c16sc_pkg::SOCKETS],
  output logic [c16sc_pkg::SOCKETS-1:0]       card_status_change_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       modem_ring_indicate_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       dma_request_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       io_read_ack_o,
  output logic                                merged_audio_out_o,
  // card pin inputs
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  battery_detect_first_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  battery_detect_second_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  card_present_first_b_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  card_present_second_b_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  io_read_acknowledge_b_i,
  input  wire logic [c16sc_pkg::SOCKETS-1:0]  card_wait_b_i,
  // card pin outputs
  output logic [c16sc_pkg::SOCKETS-1:0]       even_byte_enable_b_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       odd_byte_enable_b_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       io_read_strobe_b_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       io_write_strobe_b_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       output_enable_b_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       write_enable_b_o,
  output logic [c16sc_pkg::SOCKETS-1:0]       dma_acknowledge_b_o
);
  import c16sc_pkg::*;

  //==============================================
  // request legality
  // io cycles need io mode, dma needs io mode and enable
  function automatic logic req_legal(
    input c16sc_kind_e kind,
    input logic        io_mode,
    input logic        dma_en
  );
    logic ok;
    case (kind)
      C16SC_K_MEM_RD: ok = 1'b1;
      C16SC_K_IO_RD:  ok = io_mode;
      C16SC_K_IO_WR:  ok = io_mode;
      C16SC_K_DMA:    ok = io_mode & dma_en;
      default:        ok = 1'b0;
    endcase
    return ok;
  endfunction

  //==============================================
  // socket copies
  // one independent copy per socket
  for (genvar g = 0; g < SOCKETS; g++) begin : g_sock
    c16sc_sock_if sif ();

    c16sc_state_e     state_q;
    c16sc_state_e     state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    c16sc_kind_e      kind_q;
    c16sc_kind_e      kind_d;
    logic [1:0]       be_q;
    logic [1:0]       be_d;
    logic             to_host_q;
    logic             to_host_d;
    logic             last_q;
    logic             last_d;
    logic             busy_q;
    logic             busy_d;
    logic             done_q;
    logic             done_d;
    logic             refused_q;
    logic             refused_d;
    c16sc_pins_s      pins_q;
    c16sc_det_s       det_q;

    // mode and raw card inputs into the carrier
    assign sif.io_mode   = cfg_io_mode_i[g];
    assign sif.dma_en    = cfg_dma_en_i[g];
    assign sif.dreq_ack  = cfg_dreq_ack_i[g];
    assign sif.ring_mode = cfg_ring_mode_i[g];
    assign sif.batt1     = battery_detect_first_i[g];
    assign sif.batt2     = battery_detect_second_i[g];
    assign sif.pres1_b   = card_present_first_b_i[g];
    assign sif.pres2_b   = card_present_second_b_i[g];
    assign sif.ack_b     = io_read_acknowledge_b_i[g];

    // decode works on next state so pins line up with state_q
    assign sif.state   = state_d;
    assign sif.kind    = kind_d;
    assign sif.byte_en = be_d;
    assign sif.to_host = to_host_d;
    assign sif.last    = last_d;

    c16sc_sense u_sense (
      .s (sif)
    );

    c16sc_decode u_decode (
      .p (sif)
    );

    // cycle sequencer next state
    // wait is honoured only after the least strobe time
    always_comb begin
      state_d   = state_q;
      cnt_d     = cnt_q;
      kind_d    = kind_q;
      be_d      = be_q;
      to_host_d = to_host_q;
      last_d    = last_q;
      done_d    = 1'b0;
      refused_d = 1'b0;
      case (state_q)
        C16SC_ST_IDLE: begin
          if (req_valid_i[g]) begin
            if (det_q.present &&
                req_legal(req_kind_i[g], cfg_io_mode_i[g],
                          cfg_dma_en_i[g])) begin
              state_d   = C16SC_ST_SETUP;
              cnt_d     = SETUP_LOAD;
              kind_d    = req_kind_i[g];
              be_d      = req_byte_en_i[g];
              to_host_d = req_to_host_i[g];
              last_d    = req_last_i[g];
            end else begin
              refused_d = 1'b1;
            end
          end
        end
        C16SC_ST_SETUP: begin
          if (cnt_q == '0) begin
            state_d = C16SC_ST_STROBE;
            cnt_d   = STROBE_LOAD;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        C16SC_ST_STROBE: begin
          if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
          end else if (card_wait_b_i[g]) begin
            state_d = C16SC_ST_HOLD;
            cnt_d   = HOLD_LOAD;
          end
        end
        C16SC_ST_HOLD: begin
          if (cnt_q == '0) begin
            state_d = C16SC_ST_IDLE;
            done_d  = 1'b1;
          end else begin
            cnt_d = cnt_q - 1'b1;
          end
        end
        default: begin
          state_d = C16SC_ST_IDLE;
          cnt_d   = '0;
        end
      endcase
      busy_d = (state_d != C16SC_ST_IDLE);
    end

    // sequencer, pin and status registers
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        state_q   <= C16SC_ST_IDLE;
        cnt_q     <= '0;
        kind_q    <= C16SC_K_MEM_RD;
        be_q      <= 2'b00;
        to_host_q <= 1'b0;
        last_q    <= 1'b0;
        busy_q    <= 1'b0;
        done_q    <= 1'b0;
        refused_q <= 1'b0;
        pins_q    <= PINS_IDLE;
        det_q     <= DET_RESET;
      end else begin
        state_q   <= state_d;
        cnt_q     <= cnt_d;
        kind_q    <= kind_d;
        be_q      <= be_d;
        to_host_q <= to_host_d;
        last_q    <= last_d;
        busy_q    <= busy_d;
        done_q    <= done_d;
        refused_q <= refused_d;
        pins_q    <= sif.pins;
        det_q     <= sif.det;
      end
    end

    // outputs straight from the registers
    assign req_busy_o[g]            = busy_q;
    assign req_done_o[g]            = done_q;
    assign req_refused_o[g]         = refused_q;
    assign card_present_o[g]        = det_q.present;
    assign battery_state_o[g]       = det_q.batt;
    assign card_status_change_o[g]  = det_q.sts_chg;
    assign modem_ring_indicate_o[g] = det_q.ring;
    assign dma_request_o[g]         = det_q.dreq;
    assign io_read_ack_o[g]         = det_q.io_ack;
    assign even_byte_enable_b_o[g]  = pins_q.even_b;
    assign odd_byte_enable_b_o[g]   = pins_q.odd_b;
    assign io_read_strobe_b_o[g]    = pins_q.io_rd_b;
    assign io_write_strobe_b_o[g]   = pins_q.io_wr_b;
    assign output_enable_b_o[g]     = pins_q.oe_b;
    assign write_enable_b_o[g]      = pins_q.we_b;
    assign dma_acknowledge_b_o[g]   = pins_q.attr_b;

    //==============================================
    // checks on this socket
    chk_present_decode: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (!card_present_first_b_i[g] && !card_present_second_b_i[g])
      |=> card_present_o[g])
      else $error("present not seen with both detects low");

    chk_battery_dead: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (card_present_o[g] && !cfg_io_mode_i[g] &&
       !battery_detect_first_i[g] && !card_present_first_b_i[g] &&
       !card_present_second_b_i[g])
      |=> battery_state_o[g] == C16SC_B_DEAD)
      else $error("dead battery not decoded");

    chk_audio_io_only: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !$past(cfg_io_mode_i[g]) |-> !det_q.audio)
      else $error("audio passed outside io mode");

    chk_even_odd_enable: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      busy_q |-> (even_byte_enable_b_o[g] == !be_q[0]) &&
                 (odd_byte_enable_b_o[g] == !be_q[1]))
      else $error("byte enables do not follow request");

    chk_strobe_width: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      $fell(io_read_strobe_b_o[g]) |-> !io_read_strobe_b_o[g] [*7])
      else $error("read strobe shorter than least time");

    chk_io_write_cause: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !io_write_strobe_b_o[g] |-> state_q == C16SC_ST_STROBE &&
        (kind_q == C16SC_K_IO_WR ||
         (kind_q == C16SC_K_DMA && !to_host_q)))
      else $error("write strobe without write cycle");

    chk_mem_read_oe: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (state_q == C16SC_ST_STROBE && kind_q == C16SC_K_MEM_RD)
      |-> !output_enable_b_o[g] && io_read_strobe_b_o[g] &&
          dma_acknowledge_b_o[g])
      else $error("memory read without output enable");

    chk_count_end_oe: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (state_q == C16SC_ST_STROBE && kind_q == C16SC_K_DMA &&
       to_host_q && last_q)
      |-> !output_enable_b_o[g] && !io_read_strobe_b_o[g] &&
          write_enable_b_o[g])
      else $error("count end missing on dma write");

    chk_count_end_we: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      !write_enable_b_o[g] |-> kind_q == C16SC_K_DMA &&
        !to_host_q && last_q && !io_write_strobe_b_o[g])
      else $error("write enable outside dma read end");

    chk_dma_acknowledge_pairs: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (!dma_acknowledge_b_o[g] && state_q == C16SC_ST_STROBE)
      |-> io_read_strobe_b_o[g] != io_write_strobe_b_o[g])
      else $error("acknowledge without exactly one strobe");

    chk_refuse_mode: assert property (
      @(posedge clk_sys_i) disable iff (!rst_b_i)
      (req_valid_i[g] && !busy_q && !cfg_io_mode_i[g] &&
       req_kind_i[g] != C16SC_K_MEM_RD)
      |=> req_refused_o[g] && !req_busy_o[g])
      else $error("io cycle accepted in memory mode");
  end

  //==============================================
  // speaker merge across sockets
  logic merged_q;
  logic merged_d;

  always_comb begin
    merged_d = g_sock[SOCK_A].sif.det.audio ^
               g_sock[SOCK_B].sif.det.audio;
  end

  always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      merged_q <= 1'b0;
    end else begin
      merged_q <= merged_d;
    end
  end

  assign merged_audio_out_o = merged_q;

  chk_merged_xor: assert property (
    @(posedge clk_sys_i) disable iff (!rst_b_i)
    1'b1 |=> merged_audio_out_o ==
      ($past(g_sock[SOCK_A].sif.det.audio) ^
       $past(g_sock[SOCK_B].sif.det.audio)))
    else $error("merged audio is not the exclusive-or");
endmodule

// ===== c16sc_pkg.sv
// Notes on behaviour
// - decode good, weak and dead battery states
// - second detect is audio only in io mode
// - merge both sockets' audio onto one output
// - merged audio is exclusive-or of sockets
// - card present when both detects read low
// - first enable even bytes, second odd bytes
// - io read strobe for host io reads
// - io read strobe as dma write strobe
// - io write strobe low for io writes
// - io write strobe as dma read strobe
// - output enable low for memory reads
// - output enable marks count end, dma write
// - write enable marks count end, dma read
// - attribute select acknowledges dma with strobe

//==============================================
// shared constants and types
package c16sc_pkg;
  localparam int unsigned SOCKETS = 2;
  localparam int unsigned SOCK_A  = 0;
  localparam int unsigned SOCK_B  = 1;

  // cycle timing, all least times
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned SETUP_NS      = 30;
  localparam int unsigned STROBE_NS     = 250;
  localparam int unsigned HOLD_NS       = 20;

  // least time to whole cycles, never below one
  function automatic int unsigned ns_to_cyc(
    input int unsigned ns
  );
    int unsigned c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned SETUP_CYC  = ns_to_cyc(SETUP_NS);
  localparam int unsigned STROBE_CYC = ns_to_cyc(STROBE_NS);
  localparam int unsigned HOLD_CYC   = ns_to_cyc(HOLD_NS);
  localparam int unsigned CNT_W      = 4;
  localparam logic [CNT_W-1:0] SETUP_LOAD  = CNT_W'(SETUP_CYC - 1);
  localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC - 1);
  localparam logic [CNT_W-1:0] HOLD_LOAD   = CNT_W'(HOLD_CYC - 1);

  // card pin levels are active low
  localparam logic PIN_ON  = 1'b0;
  localparam logic PIN_OFF = 1'b1;

  typedef enum logic [1:0] {
    C16SC_K_MEM_RD = 2'b00,
    C16SC_K_IO_RD  = 2'b01,
    C16SC_K_IO_WR  = 2'b10,
    C16SC_K_DMA    = 2'b11
  } c16sc_kind_e;

  typedef enum logic [1:0] {
    C16SC_B_GOOD = 2'b00,
    C16SC_B_WEAK = 2'b01,
    C16SC_B_DEAD = 2'b10
  } c16sc_batt_e;

  typedef enum logic [1:0] {
    C16SC_ST_IDLE   = 2'b00,
    C16SC_ST_SETUP  = 2'b01,
    C16SC_ST_STROBE = 2'b10,
    C16SC_ST_HOLD   = 2'b11
  } c16sc_state_e;

  typedef struct packed {
    logic even_b;
    logic odd_b;
    logic io_rd_b;
    logic io_wr_b;
    logic oe_b;
    logic we_b;
    logic attr_b;
  } c16sc_pins_s;

  localparam c16sc_pins_s PINS_IDLE = '{
    PIN_OFF, PIN_OFF, PIN_OFF, PIN_OFF, PIN_OFF, PIN_OFF, PIN_OFF
  };

  typedef struct packed {
    logic        present;
    c16sc_batt_e batt;
    logic        sts_chg;
    logic        ring;
    logic        audio;
    logic        dreq;
    logic        io_ack;
  } c16sc_det_s;

  localparam c16sc_det_s DET_RESET = '{
    1'b0, C16SC_B_GOOD, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0
  };
endpackage

// ===== c16sc_sock_if.sv
`timescale 1ns/100ps
//==============================================
// per-socket carrier between sequencer, decode, sense
interface c16sc_sock_if;
  import c16sc_pkg::*;
  c16sc_state_e state;
  c16sc_kind_e  kind;
  logic [1:0]   byte_en;
  logic         to_host;
  logic         last;
  c16sc_pins_s  pins;
  logic         io_mode;
  logic         dma_en;
  logic         dreq_ack;
  logic         ring_mode;
  logic         batt1;
  logic         batt2;
  logic         pres1_b;
  logic         pres2_b;
  logic         ack_b;
  c16sc_det_s   det;

  modport dec (
    input  state, kind, byte_en, to_host, last,
    output pins
  );
  modport sense (
    input  io_mode, dma_en, dreq_ack, ring_mode,
    input  batt1, batt2, pres1_b, pres2_b, ack_b,
    output det
  );
endinterface

// ===== c16sc_sense.sv
`timescale 1ns/100ps
//==============================================
// card input decoding for one socket
module c16sc_sense (
  // socket carrier
  c16sc_sock_if.sense s
);
  import c16sc_pkg::*;
  c16sc_det_s d;
  logic       present;
  logic       battery_detect_second_dreq;
  logic       ack_dreq;

  // everything gated by presence so a floating socket reads quiet
  always_comb begin
    d = DET_RESET;
    present   = ~s.pres1_b & ~s.pres2_b;
    battery_detect_second_dreq = s.io_mode & s.dma_en & ~s.dreq_ack;
    ack_dreq  = s.io_mode & s.dma_en & s.dreq_ack;
    d.present = present;
    if (present && !s.io_mode) begin
      if (!s.batt1) begin
        d.batt = C16SC_B_DEAD;
      end else if (!s.batt2) begin
        d.batt = C16SC_B_WEAK;
      end else begin
        d.batt = C16SC_B_GOOD;
      end
    end
    d.sts_chg = present & s.io_mode & ~s.ring_mode & ~s.batt1;
    d.ring    = present & s.io_mode & s.ring_mode & ~s.batt1;
    d.audio   = present & s.io_mode & ~battery_detect_second_dreq & s.batt2;
    d.dreq    = present & ((battery_detect_second_dreq & ~s.batt2) |
                           (ack_dreq & ~s.ack_b));
    d.io_ack  = present & s.io_mode & ~ack_dreq & ~s.ack_b;
  end

  assign s.det = d;
endmodule

// ===== c16sc_decode.sv
`timescale 1ns/100ps
//==============================================
// card strobe levels from cycle state, one socket
module c16sc_decode (
  // socket carrier
  c16sc_sock_if.dec p
);
  import c16sc_pkg::*;
  c16sc_pins_s q;
  logic        active;
  logic        strobe;
  logic        dma_wr;
  logic        dma_rd;

  // dma write moves card to host, dma read host to card
  always_comb begin
    q      = PINS_IDLE;
    active = (p.state != C16SC_ST_IDLE);
    strobe = (p.state == C16SC_ST_STROBE);
    dma_wr = (p.kind == C16SC_K_DMA) & p.to_host;
    dma_rd = (p.kind == C16SC_K_DMA) & ~p.to_host;
    q.even_b  = ~(active & p.byte_en[0]);
    q.odd_b   = ~(active & p.byte_en[1]);
    q.io_rd_b = ~(strobe & ((p.kind == C16SC_K_IO_RD) | dma_wr));
    q.io_wr_b = ~(strobe & ((p.kind == C16SC_K_IO_WR) | dma_rd));
    q.oe_b    = ~(strobe & ((p.kind == C16SC_K_MEM_RD) |
                            (dma_wr & p.last)));
    q.we_b    = ~(strobe & dma_rd & p.last);
    // acknowledge for the whole dma cycle
    q.attr_b  = ~(active & (p.kind == C16SC_K_DMA));
  end

  assign p.pins = q;
endmodule

// ===== c16sc_card_model.sv
`timescale 1ns/100ps
//==============================================
// behavioural card pair, one card per socket
module c16sc_card_model
  import c16sc_pkg::*;
(
  // clock
  input  wire logic        clk_i,
  // card setup from bench
  input  wire logic [1:0]  present_i,
  input  wire logic [1:0]  io_card_i,
  input  wire c16sc_batt_e batt_i [2],
  input  wire logic [1:0]  evt_i,
  input  wire logic [1:0]  audio_i,
  input  wire logic [1:0]  dreq_i,
  input  wire logic [1:0]  dreq_on_ack_i,
  input  wire logic [1:0]  ack_i,
  input  wire logic [3:0]  wait_cyc_i,
  // any data strobe low, per socket
  input  wire logic [1:0]  strobe_b_i,
  // card pins toward socket
  output logic      [1:0]  batt_first_o,
  output logic      [1:0]  batt_second_o,
  output logic      [1:0]  present_b_o,
  output logic      [1:0]  ack_b_o,
  output logic      [1:0]  wait_b_o
);
  logic [3:0] wcnt_q [2] = '{4'h0, 4'h0};

  // strobe age, so wait can hold for a set count
  always @(posedge clk_i) begin
    for (int s = 0; s < 2; s++) begin
      wcnt_q[s] <= strobe_b_i[s] ? 4'h0 : wcnt_q[s] + 4'h1;
    end
  end

  // pin levels; empty slot lines sit at pull-up
  always_comb begin
    for (int s = 0; s < 2; s++) begin
      present_b_o[s]   = !present_i[s];
      batt_first_o[s]  = 1'b1;
      batt_second_o[s] = 1'b1;
      ack_b_o[s]       = 1'b1;
      wait_b_o[s] = !(present_i[s] && !strobe_b_i[s]
                      && wcnt_q[s] < wait_cyc_i);
      if (present_i[s] && !io_card_i[s]) begin
        batt_first_o[s]  = (batt_i[s] != C16SC_B_DEAD);
        batt_second_o[s] = (batt_i[s] != C16SC_B_WEAK);
      end else if (present_i[s]) begin
        // event or ring pulls first line low
        batt_first_o[s]  = !evt_i[s];
        // request on second line when selected
        batt_second_o[s] = (dreq_i[s] && !dreq_on_ack_i[s]) ? 1'b0
                                                            : audio_i[s];
        // acknowledge or request on ack line
        ack_b_o[s] = !(ack_i[s] || (dreq_i[s] && dreq_on_ack_i[s]));
      end
    end
  end
endmodule

// ===== card16_socket_control_signals_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  samples_checked++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); \
  end \
end
//==============================================
// two-socket bench with card model
module card16_socket_control_signals_tb;
  import c16sc_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_b_i   = 1'b0;
  logic [1:0]  cfg_io = 2'h0, cfg_dma = 2'h0, cfg_dma_acknowledge = 2'h0;
  logic [1:0]  cfg_ring = 2'h0, req_valid = 2'h0;
  logic [1:0]  req_th = 2'h0, req_last = 2'h0;
  c16sc_kind_e req_kind [2] = '{C16SC_K_MEM_RD, C16SC_K_MEM_RD};
  logic [1:0]  req_be [2] = '{2'h0, 2'h0};
  logic [1:0]  busy, done, refused, present, sts, ring, dreq, ack, b1, b2;
  logic [1:0]  pres_b, ack_b, wait_b, even_b, odd_b, rd_b, wr_b, oe_b;
  logic [1:0]  we_b, dma_acknowledge_b;
  logic        audio;
  c16sc_batt_e batt_st [2];
  logic [1:0]  m_pres = 2'h0, m_io = 2'h0, m_evt = 2'h0, m_aud = 2'h0;
  logic [1:0]  m_dreq = 2'h0, m_ack = 2'h0, cd2_lift = 2'h0;
  logic [3:0]  m_wait = 4'h0;
  c16sc_batt_e m_batt [2] = '{C16SC_B_GOOD, C16SC_B_GOOD};
  int          error_cnt = 0;
  int          samples_checked = 0;

  // 25 MHz clock
  always #20 clk_sys_i = ~clk_sys_i;

  c16sc_top u_dut (.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i),
    .cfg_io_mode_i(cfg_io), .cfg_dma_en_i(cfg_dma),
    .cfg_dreq_ack_i(cfg_dma_acknowledge), .cfg_ring_mode_i(cfg_ring),
    .req_valid_i(req_valid), .req_kind_i(req_kind),
    .req_byte_en_i(req_be), .req_to_host_i(req_th),
    .req_last_i(req_last), .req_busy_o(busy), .req_done_o(done),
    .req_refused_o(refused), .card_present_o(present),
    .battery_state_o(batt_st), .card_status_change_o(sts),
    .modem_ring_indicate_o(ring), .dma_request_o(dreq),
    .io_read_ack_o(ack), .merged_audio_out_o(audio),
    .battery_detect_first_i(b1), .battery_detect_second_i(b2),
    .card_present_first_b_i(pres_b),
    .card_present_second_b_i(pres_b | cd2_lift),
    .io_read_acknowledge_b_i(ack_b), .card_wait_b_i(wait_b),
    .even_byte_enable_b_o(even_b), .odd_byte_enable_b_o(odd_b),
    .io_read_strobe_b_o(rd_b), .io_write_strobe_b_o(wr_b),
    .output_enable_b_o(oe_b), .write_enable_b_o(we_b),
    .dma_acknowledge_b_o(dma_acknowledge_b));

  c16sc_card_model u_card (.clk_i(clk_sys_i), .present_i(m_pres),
    .io_card_i(m_io), .batt_i(m_batt), .evt_i(m_evt), .audio_i(m_aud),
    .dreq_i(m_dreq), .dreq_on_ack_i(cfg_dma_acknowledge), .ack_i(m_ack),
    .wait_cyc_i(m_wait), .strobe_b_i(rd_b & wr_b & oe_b),
    .batt_first_o(b1), .batt_second_o(b2), .present_b_o(pres_b),
    .ack_b_o(ack_b), .wait_b_o(wait_b));

  //==============================================
  // shared tasks
  task automatic end_of_test;
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  function automatic logic [6:0] pins(input int s);
    return {even_b[s], odd_b[s], rd_b[s], wr_b[s], oe_b[s], we_b[s],
            dma_acknowledge_b[s]};
  endfunction

  // one cycle; counts low cycles of each card strobe
  task automatic run_cyc(input int s, input c16sc_kind_e k,
      input logic [1:0] be, input logic th, input logic last,
      output int n [7]);
    int i;
    logic [6:0] p;
    n = '{default: 0};
    @(posedge clk_sys_i);
    req_valid[s] <= 1'b1;
    req_kind[s]  <= k;
    req_be[s]    <= be;
    req_th[s]    <= th;
    req_last[s]  <= last;
    @(posedge clk_sys_i);
    req_valid[s] <= 1'b0;
    for (i = 0; i < 60 && done[s] !== 1'b1; i++) begin
      @(negedge clk_sys_i);
      p = pins(s);
      for (int j = 0; j < 7; j++) n[j] += (p[6-j] === 1'b0);
    end
    if (i == 60) begin
      error_cnt++;
      end_of_test();
    end
  endtask

  //==============================================
  // scenarios
  task automatic t_batt;
    c16sc_batt_e b [3] = '{C16SC_B_GOOD, C16SC_B_WEAK, C16SC_B_DEAD};
    `CHK("no card", 1'b0, present[0])
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys_i);
      m_pres[0] <= 1'b1;
      m_batt[0] <= b[i];
      tick(2);
      `CHK("card seen", 1'b1, present[0])
      `CHK("battery", b[i], batt_st[0])
    end
    // one detect lifted alone must not count as a card
    @(posedge clk_sys_i);
    cd2_lift[0] <= 1'b1;
    tick(2);
    `CHK("one detect", 1'b0, present[0])
    @(posedge clk_sys_i);
    cd2_lift[0] <= 1'b0;
  endtask

  task automatic t_status;
    @(posedge clk_sys_i);
    m_io[0]   <= 1'b1;
    cfg_io[0] <= 1'b1;
    m_evt[0]  <= 1'b1;
    tick(2);
    `CHK("status change", 2'h1, {ring[0], sts[0]})
    @(posedge clk_sys_i);
    cfg_ring[0] <= 1'b1;
    tick(2);
    `CHK("ring", 2'h2, {ring[0], sts[0]})
    @(posedge clk_sys_i);
    m_evt[0] <= 1'b0;
    m_ack[0] <= 1'b1;
    tick(2);
    `CHK("read ack", 2'h1, {dreq[0], ack[0]})
    @(posedge clk_sys_i);
    m_ack[0]   <= 1'b0;
    m_dreq[0]  <= 1'b1;
    cfg_dma[0] <= 1'b1;
    tick(2);
    `CHK("request second", 1'b1, dreq[0])
    @(posedge clk_sys_i);
    cfg_dma_acknowledge[0] <= 1'b1;
    tick(2);
    `CHK("request on ack", 2'h2, {dreq[0], ack[0]})
    @(posedge clk_sys_i);
    m_dreq[0] <= 1'b0;
    tick(2);
    `CHK("request gone", 1'b0, dreq[0])
  endtask

  task automatic t_strobes;
    c16sc_kind_e k [6] = '{C16SC_K_MEM_RD, C16SC_K_IO_RD, C16SC_K_IO_WR,
                           C16SC_K_DMA, C16SC_K_DMA, C16SC_K_DMA};
    logic [1:0] be [6] = '{2'h1, 2'h3, 2'h2, 2'h3, 2'h3, 2'h1};
    logic [5:0] th = 6'h28;
    logic [5:0] lst = 6'h18;
    int n [7];
    int e [7];
    logic d;
    for (int i = 0; i < 6; i++) begin
      run_cyc(0, k[i], be[i], th[i], lst[i], n);
      d = (k[i] == C16SC_K_DMA);
      e[2] = (k[i] == C16SC_K_IO_RD || d && th[i]) ? 7 : 0;
      e[3] = (k[i] == C16SC_K_IO_WR || d && !th[i]) ? 7 : 0;
      e[4] = (k[i] == C16SC_K_MEM_RD || d && th[i] && lst[i]) ? 7 : 0;
      e[5] = (d && !th[i] && lst[i]) ? 7 : 0;
      `CHK("even enable", be[i][0] ? 9 : 0, n[0])
      `CHK("odd enable", be[i][1] ? 9 : 0, n[1])
      `CHK("read strobe", e[2], n[2])
      `CHK("write strobe", e[3], n[3])
      `CHK("output enable", e[4], n[4])
      `CHK("write enable", e[5], n[5])
      `CHK("dma ack", d ? 9 : 0, n[6])
    end
  endtask

  task automatic t_wait_refuse;
    int n [7];
    @(posedge clk_sys_i);
    m_wait <= 4'ha;
    run_cyc(0, C16SC_K_IO_RD, 2'h3, 1'b0, 1'b0, n);
    // model lets wait go once the strobe has been low ten cycles
    `CHK("stretched", 11, n[2])
    @(posedge clk_sys_i);
    m_wait <= 4'h0;
    cfg_io[0] <= 1'b0;
    req_valid[0] <= 1'b1;
    req_kind[0]  <= C16SC_K_IO_RD;
    @(posedge clk_sys_i);
    req_valid[0] <= 1'b0;
    @(negedge clk_sys_i);
    `CHK("refused", 2'h1, {busy[0], refused[0]})
    `CHK("pins idle", 7'h7f, pins(0))
  endtask

  task automatic t_audio;
    int n [7];
    @(posedge clk_sys_i);
    m_pres <= 2'h3;
    m_io   <= 2'h3;
    cfg_io <= 2'h3;
    cfg_dma <= 2'h0;
    for (int v = 0; v < 4; v++) begin
      m_aud <= 2'(v);
      tick(2);
      `CHK("merged audio", 1'(v[0] ^ v[1]), audio)
      @(posedge clk_sys_i);
    end
    cfg_io[0] <= 1'b0;
    m_aud <= 2'h1;
    tick(2);
    `CHK("memory mode audio", 1'b0, audio)
    run_cyc(1, C16SC_K_IO_RD, 2'h3, 1'b0, 1'b0, n);
    `CHK("socket b read", 7, n[2])
    `CHK("socket a quiet", 7'h7f, pins(0))
  endtask

  //==============================================
  // main sequence
  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_b_i <= 1'b1;
    tick(2);
    `CHK("idle pins", 7'h7f, pins(0))
    t_batt();
    t_status();
    t_strobes();
    t_wait_refuse();
    t_audio();
    end_of_test();
  end
endmodule
